// ===== rtl/asp_pkg.sv
package asp_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned BAUD_DEFAULT = 9600;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
	localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
	localparam int unsigned DATA_BITS = 7;
	localparam int unsigned STOP_BITS = 1;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [6:0] CH_CR = 7'h0d;
	localparam logic [6:0] CH_BANG = 7'h21;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_NINE = 7'h39;
	localparam logic [6:0] CH_UA = 7'h41;
	localparam logic [6:0] CH_UF = 7'h46;
	localparam logic [6:0] CH_LA = 7'h61;
	localparam logic [6:0] CH_LZ = 7'h7a;
	localparam logic [6:0] CASE_BIT = 7'h20;
	localparam int unsigned CAL_WORDS = 16;
	localparam int unsigned CAL_AW = 4;
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_HI = 2'b01,
		PS_LO = 2'b11,
		PS_CR = 2'b10
	} asp_pstate_t;
	typedef enum logic [1:0] {
		CS_READ = 2'b00,
		CS_WAIT = 2'b01,
		CS_DONE = 2'b11
	} asp_cstate_t;
endpackage : asp_pkg

// ===== rtl/asp_uart.sv
`timescale 1ns/1ns
// 7E1 serial character engine, fixed rate
module asp_uart
	import asp_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rxd,
	output logic txd,
	output logic txOe,
	input wire logic [6:0] txChar,
	input wire logic txValid,
	output logic txReady,
	output logic [6:0] rxChar,
	output logic rxValid,
	output logic rxParityErr
);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] BITC = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALFC = CW'(HALF_CYCLES - 1);
	localparam logic [3:0] FRAME = 4'(DATA_BITS + 1 + STOP_BITS);
	logic [CW-1:0] rxCnt_q;
	logic [3:0] rxBit_q;
	logic rxBusy_q;
	logic [7:0] rxSh_q;
	logic [CW-1:0] txCnt_q;
	logic [3:0] txBit_q;
	logic [9:0] txSh_q;
	logic txBusy_q;
	wire rxTick = rxBusy_q && rxCnt_q == '0;
	wire rxLast = rxTick && rxBit_q == FRAME;
	wire txTick = txBusy_q && txCnt_q == '0;
	assign txReady = !txBusy_q;
	assign txd = txBusy_q ? txSh_q[0] : 1'b1;
	// drive the shared pair only while a character is on the wire
	assign txOe = txBusy_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxBusy_q <= 1'b0;
			rxCnt_q <= '0;
			rxBit_q <= '0;
			rxSh_q <= '0;
			rxChar <= '0;
			rxValid <= 1'b0;
			rxParityErr <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if (!rxBusy_q && !rxd) begin
				rxBusy_q <= 1'b1;
				rxCnt_q <= HALFC;
				rxBit_q <= '0;
			end else if (rxBusy_q) begin
				rxCnt_q <= rxTick ? BITC : rxCnt_q - 1'b1;
				if (rxTick) begin
					rxBit_q <= rxBit_q + 1'b1;
					if (rxBit_q == 4'd0 && rxd) begin
						rxBusy_q <= 1'b0;
					end else if (rxBit_q != 4'd0 && !rxLast) begin
						rxSh_q <= {rxd, rxSh_q[7:1]};
					end
				end
				if (rxLast) begin
					rxBusy_q <= 1'b0;
					rxChar <= rxSh_q[6:0];
					rxValid <= rxd;
					rxParityErr <= rxd && (^rxSh_q);
				end
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txBusy_q <= 1'b0;
			txCnt_q <= '0;
			txBit_q <= '0;
			txSh_q <= '1;
		end else if (!txBusy_q && txValid) begin
			txBusy_q <= 1'b1;
			txCnt_q <= BITC;
			txBit_q <= '0;
			txSh_q <= {1'b1, ^txChar, txChar, 1'b0};
		end else if (txBusy_q) begin
			txCnt_q <= txTick ? BITC : txCnt_q - 1'b1;
			if (txTick) begin
				txSh_q <= {1'b1, txSh_q[9:1]};
				txBit_q <= txBit_q + 1'b1;
				if (txBit_q == FRAME) begin
					txBusy_q <= 1'b0;
				end
			end
		end
	end
endmodule : asp_uart

// ===== rtl/asp_pod.sv
`timescale 1ns/1ns
module asp_pod
	import asp_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rxd,
	output logic txd,
	output logic txOe,
	input wire logic [7:0] podAddr,
	input wire logic podAddrLoad,
	output logic [7:0] storedAddr,
	output logic addressedMode,
	output logic selected,
	output logic [6:0] cmdChar,
	output logic cmdValid,
	output logic cmdEnd,
	output logic [3:0] hexNibble,
	output logic hexIsDigit,
	input wire logic [6:0] replyChar,
	input wire logic replyValid,
	output logic replyReady,
	output logic [asp_pkg::CAL_AW-1:0] calAddr,
	output logic calRead,
	input wire logic [15:0] calData,
	input wire logic calDataValid,
	output logic [asp_pkg::CAL_WORDS*16-1:0] calTable,
	output logic calReady
);
	import asp_pkg::*;
	logic [6:0] rxChar;
	logic rxValid;
	logic rxParityErr;
	logic [6:0] txChar;
	logic txValid;
	logic txReady;
	asp_pstate_t ps_q;
	asp_cstate_t cs_q;
	logic [7:0] addr_q;
	logic sel_q;
	logic [3:0] hiNib_q;
	logic [7:0] newAddr_q;
	logic ackPend_q;
	logic midCmd_q;
	logic [CAL_AW-1:0] calIdx_q;
	logic [15:0] calMem_q [CAL_WORDS];
	asp_pstate_t ps_d;
	logic midCmd_d;
	asp_cstate_t cs_d;

	asp_uart uUart (
		.clk(clk),
		.reset_n(reset_n),
		.rxd(rxd),
		.txd(txd),
		.txOe(txOe),
		.txChar(txChar),
		.txValid(txValid),
		.txReady(txReady),
		.rxChar(rxChar),
		.rxValid(rxValid),
		.rxParityErr(rxParityErr)
	);

	// received characters are folded to upper case before any decoding
	wire goodChar = rxValid && !rxParityErr;
	wire isLower = rxChar >= CH_LA && rxChar <= CH_LZ;
	wire [6:0] upChar = isLower ? (rxChar & ~CASE_BIT) : rxChar;
	wire isDec = upChar >= CH_ZERO && upChar <= CH_NINE;
	wire isHexA = upChar >= CH_UA && upChar <= CH_UF;
	wire isHex = isDec || isHexA;
	wire [3:0] nib = isDec ? upChar[3:0] : 4'(upChar[3:0] + 4'd9);
	wire isCr = upChar == CH_CR;
	wire isBang = upChar == CH_BANG;
	wire addrMode = addr_q != ADDR_RESET;
	wire active = !addrMode || sel_q;
	wire psIdle = ps_q == PS_IDLE;
	wire psHi = ps_q == PS_HI;
	wire psLo = ps_q == PS_LO;
	wire psCr = ps_q == PS_CR;
	// a bang opens a select only at a command boundary; inside a command it is data
	wire bangOpen = isBang && !midCmd_q;
	wire [7:0] frameAddr = {hiNib_q, nib};
	// select frames naming 00 are ignored, since 00 is the unaddressed setting
	wire newNonZero = newAddr_q != ADDR_RESET;
	wire selDone = goodChar && psCr && isCr;
	wire selMatch = selDone && newAddr_q == addr_q && newNonZero;
	wire selDecide = selDone && newNonZero;
	wire ackSet = selMatch && addrMode;
	wire replyTake = replyValid && active;
	wire calTake = cs_q == CS_WAIT && calDataValid;
	wire calLast = calIdx_q == CAL_AW'(CAL_WORDS - 1);

	assign storedAddr = addr_q;
	assign addressedMode = addrMode;
	assign selected = active;
	// command stream to the command layer; select frames never pass on
	assign cmdValid = goodChar && active && psIdle && !bangOpen;
	assign cmdChar = upChar;
	assign cmdEnd = cmdValid && isCr;
	assign hexNibble = nib;
	assign hexIsDigit = isHex;
	// replies are dropped while another module holds the line
	assign txValid = ackPend_q || replyTake;
	assign txChar = ackPend_q ? CH_CR : replyChar;
	assign replyReady = !ackPend_q && (txReady || !active);
	assign calAddr = calIdx_q;
	assign calRead = cs_q == CS_READ;
	assign calReady = cs_q == CS_DONE;

	always_comb begin
		ps_d = ps_q;
		midCmd_d = midCmd_q;
		if (goodChar) begin
			unique case (ps_q)
				PS_IDLE: begin
					ps_d = bangOpen ? PS_HI : PS_IDLE;
					midCmd_d = !isCr && !bangOpen;
				end
				PS_HI: ps_d = isHex ? PS_LO : PS_IDLE;
				PS_LO: ps_d = isHex ? PS_CR : PS_IDLE;
				PS_CR: ps_d = PS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ps_q <= PS_IDLE;
			midCmd_q <= 1'b0;
		end else begin
			ps_q <= ps_d;
			midCmd_q <= midCmd_d;
		end
	end

	// address digits arrive high nibble first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hiNib_q <= '0;
			newAddr_q <= '0;
		end else if (goodChar && psHi) begin
			hiNib_q <= nib;
		end else if (goodChar && psLo) begin
			newAddr_q <= frameAddr;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= ADDR_RESET;
			sel_q <= 1'b0;
			ackPend_q <= 1'b0;
		end else begin
			if (podAddrLoad) begin
				addr_q <= podAddr;
			end
			// any valid select decides who owns the line; it persists until the next one
			if (selDecide) begin
				sel_q <= selMatch;
			end
			if (ackSet) begin
				ackPend_q <= 1'b1;
			end else if (txReady) begin
				ackPend_q <= 1'b0;
			end
		end
	end

	// calibration walk at power-up, no host involvement
	always_comb begin
		cs_d = cs_q;
		unique case (cs_q)
			CS_READ: cs_d = CS_WAIT;
			CS_WAIT: cs_d = calDataValid ? (calLast ? CS_DONE : CS_READ) : CS_WAIT;
			CS_DONE: cs_d = CS_DONE;
			default: cs_d = CS_READ;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_q <= CS_READ;
			calIdx_q <= '0;
		end else begin
			cs_q <= cs_d;
			if (calTake) begin
				calIdx_q <= calIdx_q + 1'b1;
			end
		end
	end

	// the table is not cleared by reset; every power-up rewrites all of it
	always_ff @(posedge clk) begin
		if (calTake) begin
			calMem_q[calIdx_q] <= calData;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < CAL_WORDS; gi++) begin : gCal
			assign calTable[gi*16 +: 16] = calMem_q[gi];
		end
	endgenerate
endmodule : asp_pod

// ===== dv/asp_pod_monitor.sv
`timescale 1ns/1ns
module asp_pod_monitor
	import asp_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic txd,
	input wire logic txOe,
	input wire logic [7:0] podAddr,
	input wire logic podAddrLoad,
	input wire logic [7:0] storedAddr,
	input wire logic addressedMode,
	input wire logic selected,
	input wire logic [6:0] cmdChar,
	input wire logic cmdValid,
	input wire logic cmdEnd,
	input wire logic [3:0] hexNibble,
	input wire logic hexIsDigit,
	input wire logic calRead,
	input wire logic calReady
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_MODE: assert property (addressedMode == (storedAddr != 8'h00))
		else $error("mode flag wrong");
	AST_LOAD: assert property (podAddrLoad |=> storedAddr == $past(podAddr))
		else $error("address not stored");
	AST_OPEN: assert property (!addressedMode |-> selected)
		else $error("unaddressed pod not selected");
	AST_QUIET: assert property (!selected |-> !txOe)
		else $error("unselected pod drives line");
	AST_IDLE: assert property (!txOe |-> txd)
		else $error("line not idle high");
	AST_START: assert property ($rose(txOe) |=> !txd [*8])
		else $error("no start bit");
	AST_UPPER: assert property (cmdValid |-> !(cmdChar inside {[CH_LA:CH_LZ]}))
		else $error("lower case passed");
	AST_CR: assert property (cmdEnd |-> cmdValid && cmdChar == CH_CR)
		else $error("end without CR");
	AST_PULSE: assert property (cmdValid |=> !cmdValid)
		else $error("char pulse too long");
	AST_HEX: assert property (hexIsDigit |-> hexNibble == (cmdChar <= CH_NINE ?
		4'(cmdChar - CH_ZERO) : 4'(cmdChar - CH_UA + 7'd10))) else $error("hex decode wrong");
	AST_CAL: assert property (calReady |-> !calRead)
		else $error("cal read after ready");
endmodule : asp_pod_monitor
bind asp_pod asp_pod_monitor i_mon(.clk, .reset_n, .txd, .txOe, .podAddr, .podAddrLoad,
	.storedAddr, .addressedMode, .selected, .cmdChar, .cmdValid, .cmdEnd, .hexNibble,
	.hexIsDigit, .calRead, .calReady);

// ===== dv/asp_host_model.sv
`timescale 1ns/1ns
module asp_host_model
	import asp_pkg::*;
(
	input wire logic clk,
	output logic rxd,
	input wire logic txd,
	input wire logic txOe
);
	// bias holds the shared line at mark between frames; one pod only, so no select
	initial rxd = 1'b1;
	// caller waits for the reply before the next command
	task automatic send_char(input logic [6:0] c);
		logic [9:0] fr;
		fr = {1'b1, ^c, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk) rxd = fr[i];
			repeat (BIT_CYCLES - 1) @(negedge clk);
		end
	endtask : send_char
endmodule : asp_host_model

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	import asp_pkg::*;
	logic clk, reset_n, rxd, txd, txOe, podAddrLoad, addressedMode, selected;
	logic replyValid, replyReady, calRead, calDataValid, calReady, calPend;
	logic [7:0] podAddr, storedAddr;
	logic [6:0] replyChar;
	logic [3:0] calAddr;
	logic [15:0] calData;
	logic [255:0] calTable;
	int errors, num_checks, cyc;
	asp_pod i_asp_pod(.clk, .reset_n, .rxd, .txd, .txOe, .podAddr, .podAddrLoad, .storedAddr,
		.addressedMode, .selected, .cmdChar(), .cmdValid(), .cmdEnd(), .hexNibble(),
		.hexIsDigit(), .replyChar, .replyValid, .replyReady, .calAddr, .calRead, .calData,
		.calDataValid, .calTable, .calReady);
	asp_host_model i_asp_host_model(.clk, .rxd, .txd, .txOe);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// the store answers one cycle after it sees the read strobe, while the walk waits;
	// off-pulse data is scrambled so a late capture shows up
	always @(negedge clk) begin
		calPend <= calRead;
		calDataValid <= calPend;
		calData <= calPend ? {12'hc00, calAddr} : {12'h3ff, ~calAddr};
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			errors++;
			$display("Error run expected done seen hang");
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic load_addr(input logic [7:0] a);
		@(negedge clk) podAddr = a;
		podAddrLoad = 1'b1;
		@(negedge clk) podAddrLoad = 1'b0;
		@(negedge clk);
	endtask : load_addr
	task automatic send_reply(input logic [6:0] c);
		int n;
		@(negedge clk) replyChar = c;
		replyValid = 1'b1;
		// ready is settled at the falling edge and holds to the rising edge that takes it
		while (replyReady !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		@(negedge clk) replyValid = 1'b0;
		chk("replyReady", 1, n < 100);
	endtask : send_reply
	task automatic test_cal;
		int n;
		while (calReady !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("calReady", 1, calReady);
		for (int i = 0; i < 16; i++)
			chk("calTable", {12'hc00, 4'(i)}, calTable[i*16 +: 16]);
	endtask : test_cal
	task automatic test_mode;
		logic [7:0] list [3];
		list = '{8'h01, 8'hff, 8'h00};
		foreach (list[i]) begin
			load_addr(list[i]);
			chk("addressedMode", list[i] != 8'h00, addressedMode);
			chk("selected", list[i] == 8'h00, selected);
		end
	endtask : test_mode
	task automatic test_quiet;
		int seen;
		load_addr(8'h05);
		send_reply(CH_UA);
		repeat (300) begin
			@(posedge clk);
			if (txOe !== 1'b0)
				seen++;
		end
		chk("txOe", 0, seen);
		load_addr(8'h00);
	endtask : test_quiet
	task automatic test_frame;
		logic [9:0] fr;
		int n;
		fr = {1'b1, ^7'h61, 7'h61, 1'b0};
		send_reply(7'h61);
		while (txOe !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("txOe", 1, txOe);
		repeat (HALF_CYCLES) @(negedge clk);
		for (int b = 0; b < 3; b++) begin
			chk("txd", fr[b], txd);
			repeat (BIT_CYCLES) @(negedge clk);
		end
		@(negedge clk) reset_n = 1'b0;
		@(negedge clk);
		chk("txOe", 0, txOe);
		chk("txd", 1, txd);
		reset_n = 1'b1;
		test_cal();
	endtask : test_frame
	initial begin
		reset_n = 1'b0;
		podAddr = 8'h00;
		podAddrLoad = 1'b0;
		replyChar = 7'h00;
		replyValid = 1'b0;
		repeat (12) @(negedge clk);
		chk("storedAddr", 8'h00, storedAddr);
		chk("selected", 1, selected);
		reset_n = 1'b1;
		test_cal();
		test_mode();
		test_quiet();
		test_frame();
		close_out();
	end
endmodule : testbench
